// ===== logic/adcr_pkg.sv
package adcr_pkg;

    // Register offsets; the command register sits at the offset just below the mux register.
    localparam logic [7:0] ADDR_COMMAND = 8'h04;
    localparam logic [7:0] ADDR_INPUT_SELECT = 8'h05;
    localparam logic [7:0] ADDR_FRONT_CONFIG = 8'h06;
    // Start-mode register of our own choosing; stores the two mode bits, and reads also return the busy and pending-stop flags.
    localparam logic [7:0] ADDR_START_MODE = 8'h07;

    // Reset values.
    localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
    localparam logic [7:0] FRONT_CONFIG_RESET = 8'h00;
    localparam logic [1:0] START_MODE_RESET = 2'h0;

    // Command register fields.
    localparam int CMD_KEY_LSB = 2;
    localparam int CMD_KEY_MSB = 7;
    localparam int CMD_START_BIT = 1;
    localparam int CMD_STOP_BIT = 0;
    localparam logic [5:0] RESET_KEY = 6'h16;

    // Input select field.
    localparam int INSEL_MSB = 1;
    localparam logic [1:0] INSEL_NORMAL = 2'h0;
    localparam logic [1:0] INSEL_INVERTED = 2'h1;
    localparam logic [1:0] INSEL_MIDSUPPLY = 2'h2;
    localparam logic [1:0] INSEL_COMMON_MODE = 2'h3;

    // Front-end configuration field positions.
    localparam int FC_RESOLUTION_BIT = 7;
    localparam int FC_EXT_RANGE_BIT = 6;
    localparam int FC_REF_RANGE_BIT = 5;
    localparam int FC_INP_RANGE_BIT = 4;
    localparam int FC_VCM_BIT = 3;
    localparam int FC_POS_REFERENCE_BUFFER_ENABLE_BIT = 2;
    localparam int FC_POS_INPUT_BUFFER_ENABLE_BIT = 1;
    localparam int FC_NEG_INPUT_BUFFER_ENABLE_BIT = 0;

    // Start-control modes.
    localparam logic [1:0] MODE_START_STOP = 2'h0;
    localparam logic [1:0] MODE_ONE_SHOT = 2'h1;
    localparam logic [1:0] MODE_SYNC = 2'h2;

    // Conversion length; a plain default for the demo converter sequencer.
    localparam int CONV_CYCLES = 64;

    typedef enum logic [2:0] {
        CONV_IDLE = 3'b001,
        CONV_RUN = 3'b010,
        CONV_LAST = 3'b100
    } adcr_conv_state_type;

endpackage

// ===== logic/adcr_regs.sv
`timescale 1ns/1ps
module adcr_regs
    import adcr_pkg::*;
#(
    parameter int CONV_LEN = CONV_CYCLES
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Conversion sequencer view.
    output logic converting,
    output logic conv_start_pulse,
    output logic conv_done_pulse,
    output logic soft_reset_pulse,
    // Input multiplexer controls.
    output logic [1:0] input_select,
    output logic input_inverted,
    output logic input_short_midsupply,
    output logic input_short_common_mode,
    // Front-end controls.
    output logic resolution_16bit,
    output logic extended_range_enable,
    output logic reference_range_select,
    output logic input_range_2x,
    output logic common_mode_output_enable,
    output logic pos_reference_buffer_enable,
    output logic pos_input_buffer_enable,
    output logic neg_input_buffer_enable
);

    localparam int CW = $clog2(CONV_LEN + 1);

    // The conversion counter needs at least two cycles to tell start from finish.
    if (CONV_LEN < 2) begin : g_len_check
        $error("adcr_regs: CONV_LEN must be at least 2");
    end

    logic rst_sync1_q;
    logic rst_sync2_q;
    logic rst_core_n;
    logic [1:0] insel_q;
    logic [7:0] fcfg_q;
    logic [1:0] mode_q;
    logic soft_rst_q;
    logic [7:0] rdata_q;
    logic [CW-1:0] cnt_q;
    logic stop_pend_q;
    logic done_q;
    logic start_q;
    adcr_conv_state_type state_q;
    adcr_conv_state_type state_d;

    logic wr_cmd;
    logic key_hit;
    logic start_req;
    logic stop_req;
    logic cnt_end;

    // Reset release passes two flops so the deassertion is clean against core_clk.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync1_q <= 1'b0;
            rst_sync2_q <= 1'b0;
        end else begin
            rst_sync1_q <= 1'b1;
            rst_sync2_q <= rst_sync1_q;
        end
    end
    assign rst_core_n = rst_sync2_q;

    // Command decode; the strobes live for the write cycle only, never stored.
    assign wr_cmd = reg_write && (reg_addr == ADDR_COMMAND);
    assign key_hit = wr_cmd && (reg_wdata[CMD_KEY_MSB:CMD_KEY_LSB] == RESET_KEY)
        && !reg_wdata[CMD_START_BIT] && !reg_wdata[CMD_STOP_BIT];
    // Both strobes at once and the synchronized mode cancel the request.
    assign start_req = wr_cmd && reg_wdata[CMD_START_BIT] && !reg_wdata[CMD_STOP_BIT]
        && (mode_q != MODE_SYNC);
    assign stop_req = wr_cmd && reg_wdata[CMD_STOP_BIT] && !reg_wdata[CMD_START_BIT]
        && (mode_q != MODE_SYNC);

    // Soft reset is a one-cycle pulse, held for the cycle after the keyed write.
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            soft_rst_q <= 1'b0;
        end else begin
            soft_rst_q <= key_hit;
        end
    end

    // Input select; reserved bits are simply not stored.
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            insel_q <= INPUT_SELECT_RESET[INSEL_MSB:0];
        end else if (soft_rst_q) begin
            insel_q <= INPUT_SELECT_RESET[INSEL_MSB:0];
        end else if (reg_write && reg_addr == ADDR_INPUT_SELECT) begin
            insel_q <= reg_wdata[INSEL_MSB:0];
        end
    end

    // Front-end configuration.
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            fcfg_q <= FRONT_CONFIG_RESET;
        end else if (soft_rst_q) begin
            fcfg_q <= FRONT_CONFIG_RESET;
        end else if (reg_write && reg_addr == ADDR_FRONT_CONFIG) begin
            fcfg_q <= reg_wdata;
        end
    end

    // Start-control mode.
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            mode_q <= START_MODE_RESET;
        end else if (soft_rst_q) begin
            mode_q <= START_MODE_RESET;
        end else if (reg_write && reg_addr == ADDR_START_MODE) begin
            mode_q <= reg_wdata[1:0];
        end
    end

    // Conversion sequencer: counts one conversion, then decides whether to go on.
    assign cnt_end = (cnt_q == CW'(CONV_LEN - 1));

    always_comb begin
        state_d = state_q;
        case (state_q)
            CONV_IDLE: begin
                if (start_req) begin
                    state_d = CONV_RUN;
                end
            end
            CONV_RUN: begin
                if (start_req) begin
                    state_d = CONV_RUN;
                end else if (stop_req || mode_q == MODE_ONE_SHOT) begin
                    state_d = CONV_LAST;
                end
            end
            CONV_LAST: begin
                if (start_req) begin
                    state_d = CONV_RUN;
                end else if (cnt_end) begin
                    state_d = CONV_IDLE;
                end
            end
            default: begin
                state_d = CONV_IDLE;
            end
        endcase
    end

    // A stop landing on the last cycle of a running conversion still ends after it.
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            state_q <= CONV_IDLE;
        end else if (soft_rst_q) begin
            state_q <= CONV_IDLE;
        end else if (state_q == CONV_RUN && cnt_end && !start_req
                && (stop_req || mode_q == MODE_ONE_SHOT)) begin
            state_q <= CONV_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // Cycle counter; a start request always restarts it from zero.
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            cnt_q <= '0;
        end else if (soft_rst_q || start_req || state_q == CONV_IDLE) begin
            cnt_q <= '0;
        end else if (cnt_end) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + CW'(1);
        end
    end

    // Completion and start pulses for the data path.
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            done_q <= 1'b0;
            start_q <= 1'b0;
        end else begin
            done_q <= !soft_rst_q && !start_req && state_q != CONV_IDLE && cnt_end;
            start_q <= start_req && !soft_rst_q;
        end
    end

    // Pending stop is kept only for visibility in the mode register read.
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            stop_pend_q <= 1'b0;
        end else begin
            stop_pend_q <= (state_d == CONV_LAST) && !soft_rst_q;
        end
    end

    // Read data, valid only in the cycle after the read strobe; unmapped reads are zero.
    always_ff @(posedge core_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            rdata_q <= 8'h00;
        end else if (reg_read) begin
            case (reg_addr)
                ADDR_COMMAND: rdata_q <= 8'h00;
                ADDR_INPUT_SELECT: rdata_q <= {6'h00, insel_q};
                ADDR_FRONT_CONFIG: rdata_q <= fcfg_q;
                ADDR_START_MODE: rdata_q <= {4'h0, stop_pend_q, state_q != CONV_IDLE, mode_q};
                default: rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // Sequencer outputs.
    assign converting = (state_q != CONV_IDLE);
    assign conv_start_pulse = start_q;
    assign conv_done_pulse = done_q;
    assign soft_reset_pulse = soft_rst_q;

    // Input multiplexer decode.
    assign input_select = insel_q;
    assign input_inverted = (insel_q == INSEL_INVERTED);
    assign input_short_midsupply = (insel_q == INSEL_MIDSUPPLY);
    assign input_short_common_mode = (insel_q == INSEL_COMMON_MODE);

    // Front-end decode; the high reference range overrides the 2x input range.
    assign resolution_16bit = fcfg_q[FC_RESOLUTION_BIT];
    assign extended_range_enable = fcfg_q[FC_EXT_RANGE_BIT];
    assign reference_range_select = fcfg_q[FC_REF_RANGE_BIT];
    assign input_range_2x = fcfg_q[FC_INP_RANGE_BIT] && !fcfg_q[FC_REF_RANGE_BIT];
    assign common_mode_output_enable = fcfg_q[FC_VCM_BIT];
    assign pos_reference_buffer_enable = fcfg_q[FC_POS_REFERENCE_BUFFER_ENABLE_BIT];
    assign pos_input_buffer_enable = fcfg_q[FC_POS_INPUT_BUFFER_ENABLE_BIT];
    assign neg_input_buffer_enable = fcfg_q[FC_NEG_INPUT_BUFFER_ENABLE_BIT];

endmodule

// ===== sim/adcr_host.sv
`timescale 1ns/1ps
module adcr_host
    import adcr_pkg::*;
(
    // Clock.
    input wire logic core_clk,
    // Register port toward the device.
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_write,
    output logic reg_read,
    input wire logic [7:0] reg_rdata
);
    // The bus is idle from time zero.
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
    end

    // One write; the spare edge between calls keeps every strobe a single pulse.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample mid-cycle there.
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        @(negedge core_clk);
        d = reg_rdata;
    endtask

    // The key goes out with both strobe bits clear.
    task automatic key_reset();
        wr(ADDR_COMMAND, {RESET_KEY, 2'b00});
    endtask
endmodule

// ===== sim/adcr_regs_asserts.sv
`timescale 1ns/1ps
module adcr_regs_asserts
    import adcr_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // Watched outputs.
    input wire logic converting,
    input wire logic conv_start_pulse,
    input wire logic conv_done_pulse,
    input wire logic soft_reset_pulse,
    input wire logic [1:0] input_select,
    input wire logic input_inverted,
    input wire logic input_short_midsupply,
    input wire logic input_short_common_mode,
    input wire logic resolution_16bit,
    input wire logic reference_range_select,
    input wire logic input_range_2x
);
    logic [1:0] mode_q;
    logic cmd_wr;

    // Shadow of the start mode, since the device's own copy is not a port.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= START_MODE_RESET;
        end else if (soft_reset_pulse) begin
            mode_q <= START_MODE_RESET;
        end else if (reg_write && reg_addr == ADDR_START_MODE) begin
            mode_q <= reg_wdata[1:0];
        end
    end

    // A write to the command register.
    assign cmd_wr = reg_write && reg_addr == ADDR_COMMAND;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_key_resets: assert property (
        cmd_wr && reg_wdata == {RESET_KEY, 2'b00} |=> soft_reset_pulse)
        else $error("Keyed write gave no soft reset.");
    a_key_strobes: assert property (
        cmd_wr && reg_wdata[7:2] == RESET_KEY && reg_wdata[1:0] != 2'b00 |=> !soft_reset_pulse)
        else $error("Key with a strobe bit set still reset.");
    a_cmd_reads_zero: assert property (
        reg_read && reg_addr == ADDR_COMMAND |=> reg_rdata == 8'h00)
        else $error("Command register read back nonzero.");
    a_start_runs: assert property (
        cmd_wr && reg_wdata == 8'h02 && mode_q != MODE_SYNC |=> conv_start_pulse && converting)
        else $error("Start did not launch a conversion.");
    a_sync_ignores: assert property (cmd_wr && mode_q == MODE_SYNC |=> !conv_start_pulse)
        else $error("Start acted in synchronized mode.");
    a_both_ignored: assert property (cmd_wr && reg_wdata[1:0] == 2'b11 |=> !conv_start_pulse)
        else $error("Start with stop together acted.");
    a_oneshot_ends: assert property (conv_done_pulse && mode_q == MODE_ONE_SHOT |=> !converting)
        else $error("One-shot conversion kept running.");
    a_mux_decode: assert property (
        {input_inverted, input_short_midsupply, input_short_common_mode} == {input_select
        == INSEL_INVERTED, input_select == INSEL_MIDSUPPLY, input_select == INSEL_COMMON_MODE})
        else $error("Input select decode wrong.");
    a_ref_forces: assert property (reference_range_select |-> !input_range_2x)
        else $error("High reference range left the 2x range on.");
    a_cfg_write: assert property (
        reg_write && reg_addr == ADDR_FRONT_CONFIG |=> resolution_16bit == $past(reg_wdata[7]))
        else $error("Resolution bit did not follow the write.");
endmodule

bind adcr_regs adcr_regs_asserts i_asserts (.core_clk, .rst_n, .reg_addr, .reg_wdata,
    .reg_write, .reg_read, .reg_rdata, .converting, .conv_start_pulse, .conv_done_pulse,
    .soft_reset_pulse, .input_select, .input_inverted, .input_short_midsupply,
    .input_short_common_mode, .resolution_16bit, .reference_range_select, .input_range_2x);

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb;
    import adcr_pkg::*;
    logic core_clk;
    logic rst_n;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    logic [7:0] reg_rdata;
    logic converting;
    logic conv_done_pulse;
    logic [1:0] input_select;
    logic [2:0] mux_pins;
    logic [7:0] fc_pins;
    logic [7:0] rd_q;
    logic [7:0] fc_vals [4] = '{8'hff, 8'h10, 8'h30, 8'h4a};
    int num_errors = 0;
    int checks = 0;

    // A short conversion keeps the run brief.
    adcr_regs #(.CONV_LEN(6)) i_dut (.core_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write,
        .reg_read, .reg_rdata, .converting, .conv_start_pulse(), .conv_done_pulse,
        .soft_reset_pulse(), .input_select, .input_inverted(mux_pins[0]),
        .input_short_midsupply(mux_pins[1]), .input_short_common_mode(mux_pins[2]),
        .resolution_16bit(fc_pins[7]), .extended_range_enable(fc_pins[6]),
        .reference_range_select(fc_pins[5]), .input_range_2x(fc_pins[4]),
        .common_mode_output_enable(fc_pins[3]), .pos_reference_buffer_enable(fc_pins[2]),
        .pos_input_buffer_enable(fc_pins[1]), .neg_input_buffer_enable(fc_pins[0]));
    adcr_host i_host (.core_clk, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata);

    // Free-running 250 MHz clock.
    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        i_host.rd(a, rd_q);
        chk("read", rd_q, exp);
    endtask

    task automatic summarize();
        $display("checks %0d num_errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // A missing done pulse ends the run rather than hanging it.
    task automatic wait_done();
        for (int i = 0; i < 30; i++) begin
            @(negedge core_clk);
            if (conv_done_pulse === 1'b1) begin
                return;
            end
        end
        chk("done", 8'h00, 8'h01);
        summarize();
    endtask

    // Main sequence; the first request waits out the internal reset release.
    initial begin
        rst_n = 1'b0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        rchk(ADDR_INPUT_SELECT, INPUT_SELECT_RESET);
        rchk(ADDR_FRONT_CONFIG, FRONT_CONFIG_RESET);
        rchk(8'h20, 8'h00);
        for (int c = 0; c < 4; c++) begin
            i_host.wr(ADDR_INPUT_SELECT, 8'hfc | c[7:0]);
            rchk(ADDR_INPUT_SELECT, c[7:0]);
            chk("mux", {3'h0, input_select, mux_pins},
                {3'h0, c[1:0], c == 3, c == 2, c == 1});
        end
        foreach (fc_vals[k]) begin
            i_host.wr(ADDR_FRONT_CONFIG, fc_vals[k]);
            rchk(ADDR_FRONT_CONFIG, fc_vals[k]);
            chk("front", fc_pins, fc_vals[k] & ~{3'h0, fc_vals[k][5], 4'h0});
        end
        // Start/stop mode runs on; a restart, then a stop that lets the run finish.
        i_host.wr(ADDR_COMMAND, 8'h02);
        rchk(ADDR_COMMAND, 8'h00);
        wait_done();
        chk("run", {7'h0, converting}, 8'h01);
        i_host.wr(ADDR_COMMAND, 8'h02);
        wait_done();
        i_host.wr(ADDR_COMMAND, 8'h01);
        wait_done();
        @(negedge core_clk);
        chk("stop", {7'h0, converting}, 8'h00);
        i_host.wr(ADDR_START_MODE, {6'h00, MODE_ONE_SHOT});
        i_host.wr(ADDR_COMMAND, 8'h02);
        wait_done();
        @(negedge core_clk);
        chk("oneshot", {7'h0, converting}, 8'h00);
        i_host.wr(ADDR_START_MODE, {6'h00, MODE_SYNC});
        i_host.wr(ADDR_COMMAND, 8'h02);
        // The sequencer moves on the edge that took the write, so look a half cycle later.
        @(negedge core_clk);
        chk("sync", {7'h0, converting}, 8'h00);
        i_host.wr(ADDR_START_MODE, {6'h00, MODE_START_STOP});
        i_host.wr(ADDR_COMMAND, 8'h03);
        @(negedge core_clk);
        chk("both", {7'h0, converting}, 8'h00);
        i_host.wr(ADDR_COMMAND, 8'h59);
        rchk(ADDR_FRONT_CONFIG, 8'h4a);
        i_host.key_reset();
        rchk(ADDR_FRONT_CONFIG, FRONT_CONFIG_RESET);
        rchk(ADDR_INPUT_SELECT, INPUT_SELECT_RESET);
        summarize();
    end
endmodule
